/* iop_map.svh */
// Register offsets, field positions, reset values and timing figures of the port pin controller.
`ifndef IOP_MAP_SVH
`define IOP_MAP_SVH
`define IOP_CTRL_OFS 8'h00
`define IOP_DRIVE_OFS 8'h04
`define IOP_LATCH_OFS 8'h08
`define IOP_DIR_OFS 8'h0c
`define IOP_SEG_OFS 8'h10
`define IOP_DETEN_OFS 8'h14
`define IOP_PINS_OFS 8'h18
`define IOP_EVENT_OFS 8'h1c
`define IOP_CTRL_SER_EN 5
`define IOP_CTRL_TWO_WIRE 6
`define IOP_CTRL_INT_EN 7
`define IOP_CTRL_SP3_EN 8
`define IOP_CTRL_EVCNT 9
`define IOP_CTRL_CARRIER 10
`define IOP_CTRL_ALARM 11
`define IOP_CTRL_DB_LONG 12
`define IOP_CTRL_W 13
`define IOP_CTRL_RST 13'h0000
`define IOP_DRIVE_RST 7'h00
`define IOP_LATCH_RST 16'hffff
`define IOP_DIR_RST 16'h0000
`define IOP_EV_INT 5
`define IOP_EV_SP3 6
`define IOP_RESP_OKAY 2'h0
`define IOP_RESP_SLVERR 2'h2
`define IOP_CLK_PERIOD_NS 10
`define IOP_DB_SHORT_NS 1950000
`define IOP_DB_LONG_NS 7800000
`endif

/* iop_pin_ctrl.sv */
// Pin control logic of the 4-bit controller's ports, with an AXI4-Lite register slave.
// Summary of operation
// - Interrupt pin edge and resistor type are fixed by build parameters.
// - Software enables pull resistors per whole four-bit port.
// - Debounced transition detect, per bit on input port, per port on first I/O.
// - Debounce interval is short or long, scaled to the running clock.
// - In reset two-way ports are inputs, pulls on, hold off, their latches high.
// - Optional level hold keeps undriven inputs from floating.
// - Serial port pins carry receive, transmit, clock; parallel mode in reset.
// - A two-wire serial variant shares receive and transmit on one pin.
// - Without serial use, serial-port bit 3 raises an event or ends halt.
// - Software picks push-pull or open-drain per whole serial, timer or general port.
// - Software picks push-pull or open-drain per bit of the output-only port.
// - Carrier signal drives output-only bit 2 when enabled.
// - Alarm pulse drives output-only bit 3 when enabled.
// - Output-only port reset level is fixed at build time, high or low.
// - Timer-shared bit 3 becomes event counter clock input in counter mode.
// - Six LCD drive techniques are supported on the segment outputs.
// - Each segment pin is an LCD driver or general output by build choice.
// - In reset, general segment outputs follow the all-lit or all-off choice.
// - Common outputs in use follow the duty; frame rate fixed at build.
// - Each output-only bit takes its reset level from a build choice.
`timescale 1ns/10ps
`include "iop_map.svh"
module iop_pin_ctrl import iop_pkg::*; #(
   parameter int DB_SHORT_CYC = `IOP_DB_SHORT_NS / `IOP_CLK_PERIOD_NS,
   parameter int DB_LONG_CYC = `IOP_DB_LONG_NS / `IOP_CLK_PERIOD_NS,
   parameter bit INT_RISING = 1'b0,
   parameter bit [1:0] INT_RES = 2'h0,
   parameter bit PORT_PULL_UP = 1'b1,
   parameter bit [5:0] HOLD_EN = 6'h3f,
   parameter bit [3:0] N_RST_HIGH = 4'hf,
   parameter bit [22:0] SEG_GPO = 23'h000000,
   parameter bit SEG_ALL_LIT = 1'b0,
   parameter iop_lcd_tech_t LCD_TECH = IOP_LCD_B3D4,
   parameter bit [1:0] LCD_FRAME = 2'h1
) (
   // Clock, reset and clock enable.
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // AXI4-Lite slave.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Input pins.
   input wire logic [3:0] input_only_i,
   input wire logic ext_int_i,
   // Two-way ports: first I/O, serial, timer-shared, general.
   input wire logic [3:0] cmos_io_i,
   output logic [3:0] cmos_io_o,
   output logic [3:0] cmos_io_oe,
   input wire logic [3:0] serial_port_i,
   output logic [3:0] serial_port_o,
   output logic [3:0] serial_port_oe,
   input wire logic [3:0] timer_port_i,
   output logic [3:0] timer_port_o,
   output logic [3:0] timer_port_oe,
   input wire logic [3:0] general_io_i,
   output logic [3:0] general_io_o,
   output logic [3:0] general_io_oe,
   // Output-only port.
   output logic [3:0] out_only_o,
   output logic [3:0] out_only_oe,
   // Resistor and hold controls, ports ordered input, first I/O, serial, timer, general.
   output logic [4:0] port_pull_en,
   output logic port_pull_up,
   output logic [4:0] port_hold_en,
   output logic int_pull_up_en,
   output logic int_pull_dn_en,
   output logic int_hold_en,
   // Peripheral side.
   input wire logic ser_tx_data,
   input wire logic ser_clk_out,
   input wire logic ser_clk_drive,
   output logic ser_rx_data,
   output logic ser_clk_in,
   output logic event_count_clk,
   input wire logic carrier_in,
   input wire logic alarm_in,
   output logic ext_int_pulse,
   output logic halt_release_pulse,
   // LCD side.
   input wire logic [22:0] lcd_seg_in,
   input wire logic [3:0] lcd_com_in,
   output logic [22:0] segment_drive,
   output logic [3:0] common_drive,
   output logic [1:0] lcd_frame_sel
);
   // Register state.
   logic [12:0] ctrl_r;
   logic [6:0] drive_r;
   logic [19:0] latch_r;
   logic [15:0] dir_r;
   logic [22:0] seg_r;
   logic [4:0] deten_r;
   logic [6:0] event_r;
   // Pin synchronisers, first and second stage.
   logic [20:0] pin_m_r;
   logic [20:0] pin_s_r;
   logic int_d_r;
   logic sp3_d_r;
   // Debounce state.
   logic [3:0] s_stab_r;
   logic [3:0] k_stab_r;
   iop_db_cnt_t db_cnt_r [5];
   logic [4:0] db_hit;
   // Bus handshake state.
   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   // Synchronised pin levels.
   wire [3:0] s_sync = pin_s_r[3:0];
   wire [3:0] k_sync = pin_s_r[7:4];
   wire [3:0] so_sync = pin_s_r[11:8];
   wire [3:0] m_sync = pin_s_r[15:12];
   wire [3:0] p_sync = pin_s_r[19:16];
   wire int_sync = pin_s_r[20];

   // Control fields.
   wire ser_en = ctrl_r[`IOP_CTRL_SER_EN];
   wire two_wire = ctrl_r[`IOP_CTRL_TWO_WIRE];
   wire evcnt = ctrl_r[`IOP_CTRL_EVCNT];
   wire [2:0] od_port = drive_r[2:0];
   wire [3:0] od_n = drive_r[6:3];

   // Bus decode.
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire [7:0] wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
   wire [31:0] wd = w_hold_r ? wdata_r : s_axi_wdata;
   wire [3:0] ws = w_hold_r ? wstrb_r : s_axi_wstrb;
   wire do_wr = (aw_hold_r | aw_take) & (w_hold_r | w_take) & ~s_axi_bvalid;
   wire [31:0] bmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
   wire wr_ctrl = do_wr & (wa == `IOP_CTRL_OFS);
   wire wr_drive = do_wr & (wa == `IOP_DRIVE_OFS);
   wire wr_latch = do_wr & (wa == `IOP_LATCH_OFS);
   wire wr_dir = do_wr & (wa == `IOP_DIR_OFS);
   wire wr_seg = do_wr & (wa == `IOP_SEG_OFS);
   wire wr_deten = do_wr & (wa == `IOP_DETEN_OFS);
   wire wr_event = do_wr & (wa == `IOP_EVENT_OFS);
   wire wr_hit = (wa[7:5] == 3'h0) & (wa[1:0] == 2'h0);
   wire [31:0] wmerge_ctrl = ({19'h0, ctrl_r} & ~bmask) | (wd & bmask);
   wire [31:0] wmerge_drive = ({25'h0, drive_r} & ~bmask) | (wd & bmask);
   wire [31:0] wmerge_latch = ({12'h0, latch_r} & ~bmask) | (wd & bmask);
   wire [31:0] wmerge_dir = ({16'h0, dir_r} & ~bmask) | (wd & bmask);
   wire [31:0] wmerge_seg = ({9'h0, seg_r} & ~bmask) | (wd & bmask);
   wire [31:0] wmerge_deten = ({27'h0, deten_r} & ~bmask) | (wd & bmask);
   wire [6:0] ev_clr = wr_event ? (wd[6:0] & bmask[6:0]) : 7'h00;

   // Read decode; unmapped addresses read zero with an error answer.
   wire [7:0] ra = s_axi_araddr;
   wire rd_hit = (ra[7:5] == 3'h0) & (ra[1:0] == 2'h0);
   wire [31:0] rd_val =
      (ra == `IOP_CTRL_OFS) ? {19'h0, ctrl_r} :
      (ra == `IOP_DRIVE_OFS) ? {25'h0, drive_r} :
      (ra == `IOP_LATCH_OFS) ? {12'h0, latch_r} :
      (ra == `IOP_DIR_OFS) ? {16'h0, dir_r} :
      (ra == `IOP_SEG_OFS) ? {9'h0, seg_r} :
      (ra == `IOP_DETEN_OFS) ? {27'h0, deten_r} :
      (ra == `IOP_PINS_OFS) ? {11'h0, pin_s_r} :
      (ra == `IOP_EVENT_OFS) ? {25'h0, event_r} : 32'h0;

   // Interrupt pin edge is a build choice; reception obeys the enable bit.
   wire int_edge = INT_RISING ? (int_sync & ~int_d_r) : (~int_sync & int_d_r);
   wire int_ev = int_edge & ctrl_r[`IOP_CTRL_INT_EN];
   // Serial-port bit 3 falling edge is an event only while the serial logic is off.
   wire sp3_ev = ~so_sync[3] & sp3_d_r & ~ser_en & ctrl_r[`IOP_CTRL_SP3_EN];

   // Debounce acceptance: a changed level that stays for the full interval.
   wire [19:0] db_lim = ctrl_r[`IOP_CTRL_DB_LONG] ? 20'(DB_LONG_CYC - 1)
      : 20'(DB_SHORT_CYC - 1);
   wire [4:0] db_diff = {k_sync != k_stab_r, s_sync ^ s_stab_r};
   wire [6:0] ev_set = {sp3_ev, int_ev, db_hit & deten_r};

   // Drive helper: open drain only drives the low level.
   function automatic logic [3:0] drv(input logic [3:0] en, input logic [3:0] v,
                                      input logic [3:0] od);
      drv = en & (~od | ~v);
   endfunction

   // Serial port pin values with the serial logic taking bits 0 to 2.
   wire [3:0] so_val = ser_en ? {latch_r[7], ser_clk_out, ser_tx_data, latch_r[4]}
      : latch_r[7:4];
   wire [3:0] so_en = ser_en ? {dir_r[7], ser_clk_drive, 1'b1, 1'b0} : dir_r[7:4];
   wire [3:0] so_od = {2'h0, ser_en & two_wire, 1'b0} | {4{od_port[0]}};
   // Timer port bit 3 is forced to input in event counter mode.
   wire [3:0] m_en = {dir_r[11] & ~evcnt, dir_r[10:8]};
   // Output-only port with carrier and alarm substitution.
   wire [3:0] n_val = {ctrl_r[`IOP_CTRL_ALARM] ? alarm_in : latch_r[19],
                       ctrl_r[`IOP_CTRL_CARRIER] ? carrier_in : latch_r[18],
                       latch_r[17:16]};
   // Commons in use follow the duty of the chosen technique.
   wire [3:0] com_used =
      (LCD_TECH == IOP_LCD_STATIC) ? 4'h1 :
      (LCD_TECH == IOP_LCD_DUPLEX) ? 4'h3 :
      ((LCD_TECH == IOP_LCD_B2D3) || (LCD_TECH == IOP_LCD_B3D3)) ? 4'h7 : 4'hf;

   // Pin synchronisers.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pin_m_r <= 21'h000000;
         pin_s_r <= 21'h000000;
      end else if (clk_en) begin
         pin_m_r <= {ext_int_i, general_io_i, timer_port_i, serial_port_i, cmos_io_i,
                     input_only_i};
         pin_s_r <= pin_m_r;
      end
   end

   // One debounce counter per channel: four input bits and the first I/O port.
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_db
         assign db_hit[gi] = db_diff[gi] & (db_cnt_r[gi] == db_lim);
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               db_cnt_r[gi] <= 20'h00000;
            end else if (clk_en) begin
               if (!db_diff[gi] || db_hit[gi]) begin
                  db_cnt_r[gi] <= 20'h00000;
               end else begin
                  db_cnt_r[gi] <= db_cnt_r[gi] + 20'h00001;
               end
            end
         end
      end
   endgenerate

   // Filtered levels follow accepted changes.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_stab_r <= 4'h0;
         k_stab_r <= 4'h0;
         int_d_r <= 1'b0;
         sp3_d_r <= 1'b0;
      end else if (clk_en) begin
         s_stab_r <= s_stab_r ^ (db_hit[3:0] & db_diff[3:0]);
         k_stab_r <= db_hit[4] ? k_sync : k_stab_r;
         int_d_r <= int_sync;
         sp3_d_r <= so_sync[3];
      end
   end

   // Software registers; latches and directions take their reset states.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_r <= `IOP_CTRL_RST;
         drive_r <= `IOP_DRIVE_RST;
         latch_r <= {N_RST_HIGH, `IOP_LATCH_RST};
         dir_r <= `IOP_DIR_RST;
         seg_r <= {23{SEG_ALL_LIT}};
         deten_r <= 5'h00;
      end else if (clk_en) begin
         if (wr_ctrl) ctrl_r <= wmerge_ctrl[12:0];
         if (wr_drive) drive_r <= wmerge_drive[6:0];
         if (wr_latch) latch_r <= wmerge_latch[19:0];
         if (wr_dir) dir_r <= wmerge_dir[15:0];
         if (wr_seg) seg_r <= wmerge_seg[22:0];
         if (wr_deten) deten_r <= wmerge_deten[4:0];
      end
   end

   // Sticky events; a new event wins over a clear in the same cycle.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         event_r <= 7'h00;
      end else if (clk_en) begin
         event_r <= (event_r & ~ev_clr) | ev_set;
      end
   end

   // Pin drive registers; in reset the two-way ports are inputs, the output-only port drives, and build-time levels apply.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cmos_io_o <= 4'hf;
         cmos_io_oe <= 4'h0;
         serial_port_o <= 4'hf;
         serial_port_oe <= 4'h0;
         timer_port_o <= 4'hf;
         timer_port_oe <= 4'h0;
         general_io_o <= 4'hf;
         general_io_oe <= 4'h0;
         out_only_o <= N_RST_HIGH;
         out_only_oe <= 4'hf;
         segment_drive <= {23{SEG_ALL_LIT}};
         common_drive <= 4'h0;
      end else if (clk_en) begin
         cmos_io_o <= latch_r[3:0];
         cmos_io_oe <= dir_r[3:0];
         serial_port_o <= so_val;
         serial_port_oe <= drv(so_en, so_val, so_od);
         timer_port_o <= latch_r[11:8];
         timer_port_oe <= drv(m_en, latch_r[11:8], {4{od_port[1]}});
         general_io_o <= latch_r[15:12];
         general_io_oe <= drv(dir_r[15:12], latch_r[15:12], {4{od_port[2]}});
         out_only_o <= n_val;
         out_only_oe <= drv(4'hf, n_val, od_n);
         segment_drive <= (SEG_GPO & seg_r) | (~SEG_GPO & lcd_seg_in);
         common_drive <= lcd_com_in & com_used;
      end
   end

   // Resistor and hold controls: port pulls on and port hold off while reset is held; the interrupt pin keeps its build settings.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         port_pull_en <= 5'h1f;
         port_hold_en <= 5'h00;
         port_pull_up <= PORT_PULL_UP;
         int_pull_up_en <= (INT_RES == 2'h1);
         int_pull_dn_en <= (INT_RES == 2'h0);
         int_hold_en <= HOLD_EN[5];
         lcd_frame_sel <= LCD_FRAME;
      end else if (clk_en) begin
         port_pull_en <= ctrl_r[4:0];
         port_hold_en <= HOLD_EN[4:0];
         port_pull_up <= PORT_PULL_UP;
         int_pull_up_en <= (INT_RES == 2'h1);
         int_pull_dn_en <= (INT_RES == 2'h0);
         int_hold_en <= HOLD_EN[5];
         lcd_frame_sel <= LCD_FRAME;
      end
   end

   // Peripheral-facing signals.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ser_rx_data <= 1'b1;
         ser_clk_in <= 1'b1;
         event_count_clk <= 1'b0;
         ext_int_pulse <= 1'b0;
         halt_release_pulse <= 1'b0;
      end else if (clk_en) begin
         ser_rx_data <= two_wire ? so_sync[1] : so_sync[0];
         ser_clk_in <= so_sync[2];
         event_count_clk <= evcnt & m_sync[3];
         ext_int_pulse <= int_ev;
         halt_release_pulse <= sp3_ev;
      end
   end

   // Write channel: address and data taken in either order, response after both.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IOP_RESP_OKAY;
      end else if (clk_en) begin
         aw_hold_r <= ~do_wr & (aw_hold_r | aw_take);
         w_hold_r <= ~do_wr & (w_hold_r | w_take);
         if (aw_take) awaddr_r <= s_axi_awaddr;
         if (w_take) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         s_axi_awready <= ~(~do_wr & (aw_hold_r | aw_take)) & ~do_wr
            & ~(s_axi_bvalid & ~s_axi_bready);
         s_axi_wready <= ~(~do_wr & (w_hold_r | w_take)) & ~do_wr
            & ~(s_axi_bvalid & ~s_axi_bready);
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel: data one cycle after the address is taken.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `IOP_RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= ~ar_take & ~(s_axi_rvalid & ~s_axi_rready);
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks, all on the system clock; all but the two reset checks are disabled while reset is held.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_reset_pull_state: assert property (disable iff (1'b0)
      !rst_n |=> (port_pull_en == 5'h1f) && (port_hold_en == 5'h00)
         && (cmos_io_oe == 4'h0) && (serial_port_oe == 4'h0))
      else $error("Reset port state wrong.");
   chk_reset_n_level: assert property (disable iff (1'b0)
      !rst_n |=> (out_only_o == N_RST_HIGH) && (out_only_oe == 4'hf))
      else $error("Output-only reset level wrong.");
   chk_pull_after_rel: assert property (
      $past(clk_en) && $past(rst_n) |-> port_pull_en == $past(ctrl_r[4:0]))
      else $error("Pull enables do not follow control.");
   chk_int_gated: assert property (
      ext_int_pulse |-> $past(ctrl_r[`IOP_CTRL_INT_EN]))
      else $error("Interrupt passed while disabled.");
   chk_int_edge_dir: assert property (
      ext_int_pulse |-> $past(int_sync, 1) == INT_RISING && $past(int_d_r) != INT_RISING)
      else $error("Interrupt on wrong edge.");
   chk_db_no_early: assert property (
      (db_hit[0] && clk_en) |-> db_cnt_r[0] == db_lim)
      else $error("Debounce accepted early.");
   chk_sp3_halt_gate: assert property (
      halt_release_pulse |-> $past(!ser_en))
      else $error("Halt release while serial active.");
   chk_evcnt_input: assert property (
      ($past(clk_en) && $past(evcnt)) |-> !timer_port_oe[3])
      else $error("Counter clock pin driven.");
   chk_carrier_route: assert property (
      ($past(clk_en) && $past(ctrl_r[`IOP_CTRL_CARRIER])) |-> out_only_o[2] == $past(carrier_in))
      else $error("Carrier not routed.");
   chk_alarm_route: assert property (
      ($past(clk_en) && $past(ctrl_r[`IOP_CTRL_ALARM])) |-> out_only_o[3] == $past(alarm_in))
      else $error("Alarm not routed.");
   chk_od_no_high: assert property (
      ($past(clk_en) && $past(od_n[0]) && $past(n_val[0])) |-> !out_only_oe[0])
      else $error("Open drain drove high.");
   chk_ev_set_wins: assert property (
      ($past(clk_en) && $past(ev_set[0])) |-> event_r[0])
      else $error("Event lost against clear.");
   chk_bresp_after: assert property (
      do_wr && clk_en |=> s_axi_bvalid)
      else $error("Write response missing.");

   cov_int_event: cover property (ext_int_pulse);
   cov_db_accept: cover property (db_hit[0] && deten_r[0]);
   cov_two_wire: cover property (ser_en && two_wire && serial_port_oe[1]);
   cov_rd_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule

/* iop_pin_env.sv */
// Pin-side model that resolves the level of one four-bit two-way port.
`timescale 1ns/10ps
module iop_pin_env (
   // Clock.
   input wire logic clk,
   // Device drive.
   input wire logic [3:0] o,
   input wire logic [3:0] oe,
   // External drive.
   input wire logic [3:0] ev,
   input wire logic [3:0] ee,
   // Resistor and hold state.
   input wire logic pe,
   input wire logic pu,
   input wire logic he,
   // Resolved level.
   output logic [3:0] pin
);
   logic [3:0] last_r;
   logic tog_r = 1'b0;
   logic [3:0] idle;
   // An idle line sits at its pull, its held level, or a pattern that changes every cycle.
   assign idle = pe ? {4{pu}} : (he ? last_r : {4{tog_r}});
   assign pin = (oe & o) | (~oe & ee & ev) | (~oe & ~ee & idle);
   // Remembers the level and advances the pattern.
   always_ff @(posedge clk) begin
      last_r <= pin;
      tog_r <= ~tog_r;
   end
endmodule

/* iop_pkg.sv */
// Types shared by the port pin controller.
package iop_pkg;
   typedef enum logic [2:0] {
      IOP_LCD_STATIC,
      IOP_LCD_DUPLEX,
      IOP_LCD_B2D3,
      IOP_LCD_B2D4,
      IOP_LCD_B3D3,
      IOP_LCD_B3D4
   } iop_lcd_tech_t;
   typedef logic [19:0] iop_db_cnt_t;
endpackage

/* test_iop_pin_ctrl.sv */
// Self-checking bench for the port pin controller.
`timescale 1ns/10ps
module test_iop_pin_ctrl;
   typedef struct {logic [7:0] a; logic [31:0] d; int s; logic [31:0] e;} iop_row_t;
   logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, ext_int_i = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb = 4'hf, input_only_i = 4'h0, cmos_io_i = 4'h0, ser_ev = 4'h9;
   logic [3:0] ser_ee = 4'h9, tmr_e = 4'h8, gen_e = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, lcd_frame_sel, rsp;
   logic [3:0] cmos_io_o, cmos_io_oe, serial_port_i, serial_port_o, serial_port_oe;
   logic [3:0] timer_port_i, timer_port_o, timer_port_oe, general_io_i, general_io_o;
   logic [3:0] general_io_oe, out_only_o, out_only_oe, common_drive, lcd_com_in = 4'h5;
   logic [4:0] port_pull_en, port_hold_en;
   logic port_pull_up, int_pull_up_en, int_pull_dn_en, int_hold_en, ser_rx_data, ser_clk_in;
   logic event_count_clk, ext_int_pulse, halt_release_pulse, ser_tx_data = 1'b0;
   logic ser_clk_out = 1'b0, ser_clk_drive = 1'b0, carrier_in = 1'b1, alarm_in = 1'b1;
   logic [22:0] lcd_seg_in = 23'h2aaaaa, segment_drive;
   int mismatches = 0, check_count = 0, cyc = 0;
   iop_row_t rows [15] = '{
      '{8'h00, 32'h1f, 0, 32'h1f},
      '{8'h00, 32'h0, 0, 32'h0},
      '{8'h0c, 32'hf000, 1, 32'hff},
      '{8'h0c, 32'hf000, 6, 32'hf000},
      '{8'h08, 32'hfa000, 1, 32'hfa},
      '{8'h04, 32'h4, 1, 32'h5a},
      '{8'h04, 32'h8, 2, 32'hef},
      '{8'h08, 32'ha000, 2, 32'hf0},
      '{8'h00, 32'h400, 2, 32'hf4},
      '{8'h00, 32'hc00, 2, 32'hfc},
      '{8'h00, 32'h200, 4, 32'h1},
      '{8'h10, 32'h1, 7, 32'h1},
      '{8'h00, 32'h20, 3, 32'h2},
      '{8'h00, 32'h20, 5, 32'h1},
      '{8'h00, 32'h60, 5, 32'h0}};
   // Device under test, with short debounce counts.
   iop_pin_ctrl #(.DB_SHORT_CYC(8), .DB_LONG_CYC(32), .N_RST_HIGH(4'h5),
         .SEG_GPO(23'h000001)) u_iop_pin_ctrl (.*);
   // External circuits on the serial, timer and general ports.
   iop_pin_env u_env_s (.clk(sys_clk), .o(serial_port_o), .oe(serial_port_oe), .ev(ser_ev),
      .ee(ser_ee), .pe(port_pull_en[2]), .pu(port_pull_up), .he(port_hold_en[2]),
      .pin(serial_port_i));
   iop_pin_env u_env_t (.clk(sys_clk), .o(timer_port_o), .oe(timer_port_oe), .ev(tmr_e),
      .ee(tmr_e), .pe(port_pull_en[3]), .pu(port_pull_up), .he(port_hold_en[3]),
      .pin(timer_port_i));
   iop_pin_env u_env_g (.clk(sys_clk), .o(general_io_o), .oe(general_io_oe), .ev(gen_e),
      .ee(gen_e), .pe(port_pull_en[4]), .pu(port_pull_up), .he(port_hold_en[4]),
      .pin(general_io_i));
   // Clock at 100 MHz.
   initial forever #5 sys_clk = ~sys_clk;
   // Selects the pin-side value that a table row looks at.
   function automatic logic [31:0] obs(input int s);
      case (s)
         0: obs = {27'h0, port_pull_en};
         1: obs = {24'h0, general_io_oe, general_io_o};
         2: obs = {24'h0, out_only_oe, out_only_o};
         3: obs = {28'h0, serial_port_oe};
         4: obs = {31'h0, event_count_clk};
         5: obs = {31'h0, ser_rx_data};
         default: obs = {31'h0, segment_drive[0]};
      endcase
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_r(input string n, input logic [1:0] e, input logic [1:0] g);
      chk(n, {30'h0, e}, {30'h0, g});
   endtask
   // Write with address and data offered together; the response code lands in rsp.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Read one word into rdat and its response code into rsp.
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic step(input int n, input logic [7:0] a);
      repeat (n) @(posedge sys_clk);
      rd(a);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Cuts a hang short.
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches++;
         report_and_stop();
      end
   end
   // Main sequence.
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(8'h08);
      chk("latch reset", 32'h0005ffff, rdat);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         chk_r("bresp", 2'h0, rsp);
         if (rows[i].s == 6) rd(rows[i].a);
         repeat (5) @(posedge sys_clk);
         chk($sformatf("row %0d", i), rows[i].e, rows[i].s == 6 ? rdat : obs(rows[i].s));
      end
      ser_tx_data <= 1'b1;
      ser_clk_drive <= 1'b1;
      ser_clk_out <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chk("serial release", 32'h9, {serial_port_oe, serial_port_o[2]});
      $display("table test done");
      wr(8'h14, 32'h1);
      input_only_i[0] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      input_only_i[0] <= 1'b0;
      step(20, 8'h1c);
      chk("glitch", 32'h0, rdat);
      input_only_i[0] <= 1'b1;
      step(20, 8'h1c);
      chk("edge", 32'h1, rdat);
      wr(8'h1c, 32'h7f);
      wr(8'h00, 32'h1000);
      input_only_i[0] <= 1'b0;
      step(20, 8'h1c);
      chk("long early", 32'h0, rdat);
      step(20, 8'h1c);
      chk("long", 32'h1, rdat);
      $display("debounce test done");
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("reset pins", {cmos_io_oe, cmos_io_o, serial_port_oe, serial_port_o, timer_port_oe,
         timer_port_o, general_io_oe, general_io_o}, 32'h0f0f0f0f);
      chk("reset out", {out_only_oe, out_only_o}, 32'hf5);
      chk("reset pull", {port_pull_en, port_hold_en}, 32'h3e0);
      chk("reset seg", 32'h0, segment_drive[0]);
      repeat (20000) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("run pull", {port_pull_en, port_hold_en}, 32'h1f);
      ext_int_i <= 1'b0;
      ser_ev <= 4'h1;
      step(6, 8'h1c);
      chk("int off", 32'h0, rdat);
      wr(8'h00, 32'h180);
      ext_int_i <= 1'b1;
      ser_ev <= 4'h9;
      step(6, 8'h1c);
      chk("rise", 32'h0, rdat);
      ext_int_i <= 1'b0;
      ser_ev <= 4'h1;
      step(6, 8'h1c);
      chk("fall", 32'h60, rdat);
      $display("reset and event test done");
      wr(8'h40, 32'h1);
      chk_r("bresp unmapped", 2'h2, rsp);
      rd(8'h40);
      chk_r("rresp unmapped", 2'h2, rsp);
      chk("rdata unmapped", 32'h0, rdat);
      chk("lcd", 32'h05555555, {lcd_frame_sel, common_drive, segment_drive[22:1]});
      $display("misc test done");
      report_and_stop();
   end
endmodule
